//--- cct_timer.sv
// cct_timer: 16-bit capture/compare timer, AHB-Lite slave
// assumes: single word transfers, byte registers in hwdata/hrdata [7:0]
`timescale 1ns/1ps
`default_nettype none
module cct_timer
  import cct_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins and interrupt
  input  wire logic        captureInputPin,
  output logic             compareOutputPin,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////
  logic [15:0] count;
  logic        tick;
  logic        wrapped;
  logic        capEdge;

  logic        captureEdgeSelect;
  logic        compareOutputLevel;
  logic        captureIrqEnable;
  logic        matchIrqEnable;
  logic        wrapIrqEnable;
  logic        captureFlag;
  logic        matchFlag;
  logic        wrapFlag;
  logic [7:0]  eventMask;
  logic [15:0] captureValue;
  logic [15:0] matchValue;
  logic [7:0]  primaryLowBuf;
  logic        primaryHeld;
  logic [7:0]  altLowBuf;
  logic        altHeld;
  logic        captureBlocked;
  logic        matchBlocked;
  logic [2:0]  armed;

  cct_prescaler #(.DIV(PRESCALE), .WIDTH(16)) uPrescaler (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .tick    (tick),
    .count   (count),
    .wrapped (wrapped)
  );

  cct_edge_detect uEdge (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .pinIn     (captureInputPin),
    .risingSel (captureEdgeSelect),
    .edgeSeen  (capEdge)
  );

  ////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic       dpValid;
  logic       dpWrite;
  logic [5:0] dpIdx;
  logic       dpMapped;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpIdx   <= '0;
    end else if (hready) begin
      dpValid <= hsel && htrans[1];
      dpWrite <= hwrite;
      dpIdx   <= haddr[7:2];
    end
  end

  assign dpMapped = (haddr[31:8] == '0);
  logic rd;
  logic wr;
  assign rd = dpValid && !dpWrite;
  assign wr = dpValid && dpWrite;
  logic [7:0] wbyte;
  assign wbyte = hwdata[7:0];

  // zero-wait slave: every transfer answers OKAY in its data phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control register; edge select only loaded by software
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      compareOutputLevel <= 1'b0;
      captureIrqEnable   <= 1'b0;
      matchIrqEnable     <= 1'b0;
      wrapIrqEnable      <= 1'b0;
    end else if (wr && dpIdx == IDX_CONTROL) begin
      compareOutputLevel <= wbyte[BIT_LEVEL];
      captureIrqEnable   <= wbyte[BIT_CAP_IE];
      matchIrqEnable     <= wbyte[BIT_MAT_IE];
      wrapIrqEnable      <= wbyte[BIT_WRAP_IE];
    end
  end

  always_ff @(posedge mclk) begin
    if (wr && dpIdx == IDX_CONTROL) begin
      captureEdgeSelect <= wbyte[BIT_EDGE];
    end else begin
      captureEdgeSelect <= captureEdgeSelect === 1'bx ? 1'b0 : captureEdgeSelect;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      eventMask <= MASK_RESET;
    end else if (wr && dpIdx == IDX_IRQ_MASK) begin
      eventMask <= wbyte & FLAG_BITS;
    end
  end

  ////////////////////////////////////////////////////////////////
  // capture and match values
  // capture lockout
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      captureBlocked <= 1'b0;
    end else if (rd && dpIdx == IDX_CAP_LO) begin
      captureBlocked <= 1'b0;
    end else if (rd && dpIdx == IDX_CAP_HI) begin
      captureBlocked <= 1'b1;
    end
  end

  logic doCapture;
  assign doCapture = capEdge && !captureBlocked;

  always_ff @(posedge mclk) begin
    if (doCapture) begin
      captureValue <= count;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      matchBlocked <= 1'b0;
    end else if (wr && dpIdx == IDX_MAT_LO) begin
      matchBlocked <= 1'b0;
    end else if (wr && dpIdx == IDX_MAT_HI) begin
      matchBlocked <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (wr && dpIdx == IDX_MAT_HI) begin
      matchValue[15:8] <= wbyte;
    end
    if (wr && dpIdx == IDX_MAT_LO) begin
      matchValue[7:0] <= wbyte;
    end
  end

  logic doMatch;
  assign doMatch = tick && !matchBlocked && (count == matchValue);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      compareOutputPin <= 1'b0;
    end else if (doMatch) begin
      compareOutputPin <= compareOutputLevel;
    end
  end

  ////////////////////////////////////////////////////////////////
  // counter views
  // low byte frozen at the first high read's address phase since the last low read, the same cycle
  // whose count the high byte returns, so a low-byte carry cannot split them
  logic rdAddr;
  assign rdAddr = hready && hsel && htrans[1] && !hwrite && dpMapped;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      primaryHeld   <= 1'b0;
      primaryLowBuf <= COUNT_RESET[7:0];
    end else if (rdAddr && haddr[7:2] == IDX_PRI_HI) begin
      if (!primaryHeld) begin
        primaryLowBuf <= count[7:0];
      end
      primaryHeld <= 1'b1;
    end else if (rd && dpIdx == IDX_PRI_LO) begin
      primaryHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      altHeld   <= 1'b0;
      altLowBuf <= COUNT_RESET[7:0];
    end else if (rdAddr && haddr[7:2] == IDX_ALT_HI) begin
      if (!altHeld) begin
        altLowBuf <= count[7:0];
      end
      altHeld <= 1'b1;
    end else if (rd && dpIdx == IDX_ALT_LO) begin
      altHeld <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // flags: armed from their value in a flags read's data phase; set beats clear
  logic flagsRead;
  logic clrCap;
  logic clrMat;
  logic clrWrap;
  assign flagsRead = rd && dpIdx == IDX_FLAGS;
  assign clrCap  = armed[2] && rd && dpIdx == IDX_CAP_LO;
  assign clrMat  = armed[1] && dpValid && dpIdx == IDX_MAT_LO;
  assign clrWrap = armed[0] && dpValid && dpIdx == IDX_PRI_LO;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      armed <= '0;
    end else if (flagsRead) begin
      armed <= {captureFlag, matchFlag, wrapFlag};
    end else begin
      armed <= armed & ~{clrCap, clrMat, clrWrap};
    end
  end

  // flags keep their value through reset
  always_ff @(posedge mclk) begin
    if (doCapture) begin
      captureFlag <= 1'b1;
    end else if (clrCap || captureFlag === 1'bx) begin
      captureFlag <= 1'b0;
    end
    if (doMatch) begin
      matchFlag <= 1'b1;
    end else if (clrMat || matchFlag === 1'bx) begin
      matchFlag <= 1'b0;
    end
    if (wrapped) begin
      wrapFlag <= 1'b1;
    end else if (clrWrap || wrapFlag === 1'bx) begin
      wrapFlag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= (captureFlag && captureIrqEnable && eventMask[BIT_CAP_F])
          || (matchFlag && matchIrqEnable && eventMask[BIT_MAT_F])
          || (wrapFlag && wrapIrqEnable && eventMask[BIT_WRAP_F]);
    end
  end

  ////////////////////////////////////////////////////////////////
  // read data, registered at the address phase
  logic [7:0] next_rbyte;
  always_comb begin
    next_rbyte = 8'h00;
    unique case (haddr[7:2])
      IDX_CONTROL:  next_rbyte = {captureIrqEnable, matchIrqEnable, wrapIrqEnable,
                                  3'b000, captureEdgeSelect, compareOutputLevel};
      IDX_FLAGS:    next_rbyte = {captureFlag, matchFlag, wrapFlag, 5'b0_0000};
      IDX_CAP_HI:   next_rbyte = captureValue[15:8];
      IDX_CAP_LO:   next_rbyte = captureValue[7:0];
      IDX_MAT_HI:   next_rbyte = matchValue[15:8];
      IDX_MAT_LO:   next_rbyte = matchValue[7:0];
      IDX_PRI_HI:   next_rbyte = count[15:8];
      IDX_PRI_LO:   next_rbyte = primaryHeld ? primaryLowBuf : count[7:0];
      IDX_ALT_HI:   next_rbyte = count[15:8];
      IDX_ALT_LO:   next_rbyte = altHeld ? altLowBuf : count[7:0];
      IDX_IRQ_MASK: next_rbyte = eventMask;
      default:      next_rbyte = 8'h00;
    endcase
    if (!dpMapped) begin
      next_rbyte = 8'h00;
    end
  end

  // read data sampled one cycle ahead; high byte reads return
  // the count of the address-phase cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= {24'h00_0000, next_rbyte};
    end
  end

  logic unusedBits;
  assign unusedBits = ^{hsize, hwdata[31:8]};
endmodule
`default_nettype wire

//--- cct_pkg.sv
// cct_pkg: constants shared by the capture/compare timer files
// assumes: AHB-Lite word map, byte registers in the low lanes
package cct_pkg;
  // byte register indices (byte address = 4 * index)
  localparam logic [5:0] IDX_CONTROL  = 6'h12;
  localparam logic [5:0] IDX_FLAGS    = 6'h13;
  localparam logic [5:0] IDX_CAP_HI   = 6'h14;
  localparam logic [5:0] IDX_CAP_LO   = 6'h15;
  localparam logic [5:0] IDX_MAT_HI   = 6'h16;
  localparam logic [5:0] IDX_MAT_LO   = 6'h17;
  localparam logic [5:0] IDX_PRI_HI   = 6'h18;
  localparam logic [5:0] IDX_PRI_LO   = 6'h19;
  localparam logic [5:0] IDX_ALT_HI   = 6'h1A;
  localparam logic [5:0] IDX_ALT_LO   = 6'h1B;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h1C;
  // control bit positions
  localparam int BIT_CAP_IE  = 7;
  localparam int BIT_MAT_IE  = 6;
  localparam int BIT_WRAP_IE = 5;
  localparam int BIT_EDGE    = 1;
  localparam int BIT_LEVEL   = 0;
  // flag bit positions (also the event mask layout)
  localparam int BIT_CAP_F  = 7;
  localparam int BIT_MAT_F  = 6;
  localparam int BIT_WRAP_F = 5;
  localparam logic [7:0] FLAG_BITS = 8'hE0;
  // reset values
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  // prescaler
  localparam int PRESCALE = 4;
endpackage

//--- cct_prescaler.sv
// cct_prescaler: divide-by-N tick and the free-running counter
// assumes: one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module cct_prescaler
  import cct_pkg::*;
#(
  parameter int DIV   = PRESCALE,
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // counter
  output logic                  tick,
  output logic [WIDTH-1:0]      count,
  output logic                  wrapped
);
  initial if (DIV < 2 || WIDTH != 16) $error("cct_prescaler: bad parameter");

  localparam int PW = $clog2(DIV);
  logic [PW-1:0] phase;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= '0;
    end else if (phase == PW'(DIV - 1)) begin
      phase <= '0;
    end else begin
      phase <= phase + PW'(1);
    end
  end

  assign tick = (phase == PW'(DIV - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= COUNT_RESET;
    end else if (tick) begin
      count <= count + WIDTH'(1);
    end
  end

  assign wrapped = tick && (count == '1);
endmodule
`default_nettype wire

//--- cct_edge_detect.sv
// cct_edge_detect: two-flop sync of the capture pin plus edge pick
// assumes: pin is asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module cct_edge_detect (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // pin and selection
  input  wire logic pinIn,
  input  wire logic risingSel,
  output logic      edgeSeen
);
  logic syncA;
  logic syncB;
  logic last;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      last  <= 1'b0;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      last  <= syncB;
    end
  end

  assign edgeSeen = risingSel ? (syncB && !last) : (!syncB && last);
endmodule
`default_nettype wire

//--- cct_timer_properties.sv
// cct_timer_checker: port-level properties of the timer
// assumes: bound into cct_timer, hready fed from hreadyout
`timescale 1ns/1ps
`default_nettype none
module cct_timer_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins
  input wire logic        compareOutputPin,
  input wire logic        irq
);
  logic       dpRd;
  logic       dpWr;
  logic [7:0] dpA;
  logic [7:0] ctl;
  logic       maskOff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dpRd <= 1'b0;
      dpWr <= 1'b0;
      dpA  <= 8'h00;
    end else if (hready) begin
      dpRd <= hsel && htrans[1] && !hwrite;
      dpWr <= hsel && htrans[1] && hwrite;
      dpA  <= haddr[7:0];
    end
  end
  // edge select survives reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl     <= 8'h00;
      maskOff <= 1'b1;
    end else if (dpWr && hready && dpA == 8'h48) begin
      ctl <= hwdata[7:0];
    end else if (dpWr && hready && dpA == 8'h70) begin
      maskOff <= hwdata[7:5] == 3'b000;
    end
  end
  AST_NO_STALL: assert property (hreadyout) else $error("wait state inserted");
  AST_OKAY_ONLY: assert property (!hresp) else $error("error response");
  AST_UPPER_ZERO: assert property (dpRd |-> hrdata[31:8] == 24'h00_0000) else $error("upper bits set");
  AST_UNMAPPED_ZERO: assert property (dpRd && (dpA < 8'h48 || dpA > 8'h70) |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_CTRL_BACK: assert property (dpRd && dpA == 8'h48 |-> (hrdata[7:0] & 8'hE1) == (ctl & 8'hE1))
    else $error("control readback wrong");
  AST_MATCH_SPACING: assert property ($changed(compareOutputPin) |=> $stable(compareOutputPin) [*3])
    else $error("compare pin moved off tick");
  AST_MATCH_LEVEL: assert property ($changed(compareOutputPin) |-> compareOutputPin == $past(ctl[0]))
    else $error("compare pin level wrong");
  AST_IRQ_MASKED: assert property (maskOff && $past(maskOff) |-> !irq) else $error("irq while masked");
  COV_MATCH: cover property ($rose(compareOutputPin));
  COV_IRQ: cover property ($rose(irq));
  COV_PRI_READ: cover property (dpRd && dpA == 8'h60);
endmodule
bind cct_timer cct_timer_checker u_chk (.mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .compareOutputPin, .irq);
`default_nettype wire

//--- cct_event_source.sv
// cct_event_source: external event source on the capture pin
// assumes: bench calls setLevel just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cct_event_source (
  // clock
  input wire logic mclk,
  // capture pin
  output logic     capturePin
);
  initial capturePin = 1'b0;
  task automatic setLevel(input logic level);
    capturePin <= level;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

//--- cct_timer_test.sv
// cct_timer_test: self-checking bench for the capture/compare timer
// assumes: zero-wait slave, byte registers in data bits 7:0
`timescale 1ns/1ps
`default_nettype none
module cct_timer_test
  import cct_pkg::*;
;
  logic        mclk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        capPin;
  logic        cmpPin;
  logic        irq;
  logic [7:0]  b;
  logic [15:0] v0;
  logic [15:0] v1;
  int          failCount;
  int          comparisons;
  cct_event_source src (.mclk(mclk), .capturePin(capPin));
  cct_timer DUT (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .captureInputPin(capPin), .compareOutputPin(cmpPin), .irq(irq));
  always #5 mclk = ~mclk;
  ////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic same(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      failCount++;
      summarize();
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    waitRdy();
    htrans <= 2'b00;
    hwdata <= 32'(d);
    waitRdy();
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    xfer(a, 1'b0, 8'h00, r);
    same(16'(r & m), 16'(e));
  endtask
  // high byte first so the low byte comes from the frozen buffer
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    xfer(a, 1'b0, 8'h00, v[15:8]);
    xfer(a + 8'h04, 1'b0, 8'h00, v[7:0]);
  endtask
  task automatic waitPin(input logic lvl);
    int n;
    n = 0;
    while (cmpPin !== lvl && n < 200) begin
      @(posedge mclk);
      n++;
    end
    same(16'(cmpPin), 16'(lvl));
    if (cmpPin !== lvl) summarize();
  endtask
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    failCount = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    chk(8'h60, 8'hFF, COUNT_RESET[15:8]);
    chk(8'h64, 8'hFE, COUNT_RESET[7:0]);
    rd16(8'h60, v0);
    wr(8'h60, 8'h12);
    wr(8'h64, 8'h34);
    rd16(8'h60, v1);
    same(v1, v0 + 16'h0002);
    xfer(8'h60, 1'b0, 8'h00, b);
    repeat (36) @(posedge mclk);
    xfer(8'h60, 1'b0, 8'h00, b);
    chk(8'h64, 8'hFF, v1[7:0] + 8'h01);
    xfer(8'h68, 1'b0, 8'h00, v0[15:8]);
    xfer(8'h68, 1'b0, 8'h00, b);
    rd16(8'h60, v1);
    xfer(8'h6C, 1'b0, 8'h00, v0[7:0]);
    same(v1, v0 + 16'h0001);
    $display("test 1 counter views done");
    wr(8'h70, 8'h20);
    wr(8'h48, 8'h20);
    chk(8'h4C, 8'h20, 8'h20);
    chk(8'h48, 8'hE1, 8'h20);
    same(16'(irq), 16'h0001);
    xfer(8'h6C, 1'b0, 8'h00, b);
    chk(8'h4C, 8'h20, 8'h20);
    xfer(8'h64, 1'b0, 8'h00, b);
    chk(8'h4C, 8'h20, 8'h00);
    repeat (2) @(posedge mclk);
    same(16'(irq), 16'h0000);
    $display("test 2 wrap flag done");
    wr(8'h48, 8'h82);
    wr(8'h70, 8'h80);
    rd16(8'h60, v0);
    src.setLevel(1'b1);
    repeat (8) @(posedge mclk);
    chk(8'h4C, 8'h80, 8'h80);
    same(16'(irq), 16'h0001);
    rd16(8'h50, v1);
    same(16'(v1 - v0 - 16'h0001 < 16'h0004), 16'h0001);
    chk(8'h4C, 8'h80, 8'h00);
    src.setLevel(1'b0);
    repeat (8) @(posedge mclk);
    chk(8'h4C, 8'h80, 8'h00);
    xfer(8'h50, 1'b0, 8'h00, b);
    src.setLevel(1'b1);
    repeat (8) @(posedge mclk);
    xfer(8'h54, 1'b0, 8'h00, b);
    same(16'(b), 16'(v1[7:0]));
    wr(8'h48, 8'h80);
    src.setLevel(1'b0);
    repeat (8) @(posedge mclk);
    chk(8'h4C, 8'h80, 8'h80);
    $display("test 3 capture done");
    wr(8'h48, 8'hE3);
    rst_b <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    chk(8'h48, 8'hE3, 8'h02);
    chk(8'h4C, 8'h80, 8'h80);
    chk(8'h60, 8'hFF, COUNT_RESET[15:8]);
    $display("test 4 second reset done");
    wr(8'h48, 8'h41);
    wr(8'h70, 8'h40);
    rd16(8'h60, v0);
    v1 = v0 + 16'h0014;
    wr(8'h58, v1[15:8]);
    xfer(8'h4C, 1'b0, 8'h00, b);
    wr(8'h5C, v1[7:0]);
    chk(8'h4C, 8'h40, 8'h00);
    same(16'(cmpPin), 16'h0000);
    waitPin(1'b1);
    chk(8'h4C, 8'h40, 8'h40);
    same(16'(irq), 16'h0001);
    wr(8'h48, 8'h40);
    rd16(8'h60, v0);
    v1 = v0 + 16'h0010;
    wr(8'h5C, v1[7:0]);
    wr(8'h58, v1[15:8]);
    repeat (100) @(posedge mclk);
    same(16'(cmpPin), 16'h0001);
    rd16(8'h60, v0);
    v1 = v0 + 16'h000A;
    wr(8'h58, v1[15:8]);
    wr(8'h5C, v1[7:0]);
    waitPin(1'b0);
    chk(8'h7C, 8'hFF, 8'h00);
    $display("test 5 compare done");
    summarize();
  end
endmodule
`default_nettype wire
